// ===== mbg_pkg.sv
`default_nettype none
package mbg_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int WAIT_STATE_MS = 150;
  localparam int WAIT_STATE_CYC = (CLK_HZ / 1000) * WAIT_STATE_MS;
  localparam int TMR_W = 26;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_WAIT = 5'h04;
  localparam logic [4:0] A_RETRY = 5'h08;
  localparam logic [4:0] A_OWNID = 5'h0C;
  localparam logic [4:0] A_SCAN = 5'h10;
  localparam logic [4:0] A_STAT = 5'h14;
  localparam logic [4:0] A_MASK = 5'h18;
  localparam logic [4:0] A_STATE = 5'h1C;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 2;
  localparam int FLD_W = 2;
  localparam logic [7:0] WAIT_RST = 8'h55;
  localparam logic [7:0] RETRY_RST = 8'hAA;
  localparam logic [7:0] OWNID_RST = 8'h01;
  localparam int ST_DONE = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_LOCAL = 3;
  localparam int NCONN = 4;

  // ----------------------------------------------------------------
  // protocol codes
  // ----------------------------------------------------------------
  localparam int FC_EXC_BIT = 7;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BUSY = 8'h06;
  localparam logic [7:0] EXC_PATH = 8'h0A;
  localparam logic [7:0] EXC_NO_REPLY = 8'h0B;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] tid;
    logic [7:0] uid;
    logic [7:0] fc;
    logic [31:0] data;
    logic [1:0] conn;
  } mbg_req_t;

  typedef struct packed {
    logic [15:0] tid;
    logic [7:0] uid;
    logic [7:0] fc;
    logic [31:0] data;
  } mbg_rsp_t;

  typedef struct packed {
    logic [7:0] uid;
    logic [7:0] fc;
    logic [31:0] data;
  } mbg_frame_t;
endpackage : mbg_pkg
`default_nettype wire

// ===== mbg_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mbg_timer #(
  parameter int CYC = mbg_pkg::WAIT_STATE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  input wire logic [1:0] ws,
  output logic expire
);
  import mbg_pkg::*;

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;
  logic [TMR_W-1:0] load;

  // zero wait states still leaves one cycle to catch a reply
  always_comb begin
    load = TMR_W'(ws) * TMR_W'(CYC);
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = (load == '0) ? TMR_W'(1) : load;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - TMR_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expire = (cnt_reg == TMR_W'(1)) && !start;

  a_wait_length: assert property (@(posedge aclk) disable iff (!aresetn)
    start && ws == 2'd1 |=> cnt_reg == TMR_W'(CYC))
    else $error("wait timer not loaded with one wait state");
endmodule : mbg_timer
`default_nettype wire

// ===== mbg_arb.sv
`timescale 1ns/1ps
`default_nettype none
module mbg_arb (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requesters
  input wire logic gw_req,
  input wire logic lm_req,
  output logic gw_grant,
  output logic lm_grant
);
  import mbg_pkg::*;

  typedef enum logic [2:0] {
    A_IDLE = 3'b001,
    A_GW = 3'b010,
    A_LM = 3'b100
  } mbg_arb_t;

  mbg_arb_t own_reg;
  mbg_arb_t own_next;
  logic last_lm_reg;
  logic last_lm_next;

  // whole transactions are granted; alternate on contention so neither side starves
  always_comb begin
    own_next = own_reg;
    last_lm_next = last_lm_reg;
    unique case (own_reg)
      A_IDLE: begin
        if (gw_req && (!lm_req || last_lm_reg)) begin
          own_next = A_GW;
        end else if (lm_req) begin
          own_next = A_LM;
        end
      end
      A_GW: begin
        if (!gw_req) begin
          own_next = A_IDLE;
          last_lm_next = 1'b0;
        end
      end
      A_LM: begin
        if (!lm_req) begin
          own_next = A_IDLE;
          last_lm_next = 1'b1;
        end
      end
      default: own_next = A_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_reg <= A_IDLE;
      last_lm_reg <= 1'b1;
    end else begin
      own_reg <= own_next;
      last_lm_reg <= last_lm_next;
    end
  end

  assign gw_grant = (own_reg == A_GW);
  assign lm_grant = (own_reg == A_LM);

  a_grant_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    gw_grant && gw_req |=> gw_grant && !lm_grant)
    else $error("gateway lost the serial port mid transaction");
endmodule : mbg_arb
`default_nettype wire

// ===== mbg_gateway.sv
`timescale 1ns/1ps
`default_nettype none
module mbg_gateway #(
  parameter int WAIT_CYCLES = mbg_pkg::WAIT_STATE_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // tcp side
  input wire logic tcp_req_valid,
  output logic tcp_req_ready,
  input wire mbg_pkg::mbg_req_t tcp_req,
  output logic tcp_rsp_valid,
  input wire logic tcp_rsp_ready,
  output mbg_pkg::mbg_rsp_t tcp_rsp,
  // local server
  output logic loc_req_valid,
  input wire logic loc_req_ready,
  output mbg_pkg::mbg_req_t loc_req,
  input wire logic loc_rsp_valid,
  output logic loc_rsp_ready,
  input wire mbg_pkg::mbg_rsp_t loc_rsp,
  // serial side
  output logic [2:0] rtu_port,
  output logic rtu_tx_valid,
  input wire logic rtu_tx_ready,
  output mbg_pkg::mbg_frame_t rtu_tx,
  input wire logic rtu_rx_valid,
  input wire mbg_pkg::mbg_frame_t rtu_rx,
  // local master
  input wire logic lm_req,
  output logic lm_grant,
  input wire logic lm_tx_valid,
  output logic lm_tx_ready,
  input wire mbg_pkg::mbg_frame_t lm_tx,
  output logic lm_rx_valid
);
  import mbg_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ARB = 5'b00010,
    S_SEND = 5'b00100,
    S_WAIT = 5'b01000,
    S_DONE = 5'b10000
  } mbg_st_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next, bv_reg, bv_next;
  logic [4:0] aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next;
  logic wb_reg, wb_next;
  logic [1:0] br_reg, br_next;
  logic rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  logic [1:0] port_reg, port_next;
  logic en_reg, en_next;
  logic [7:0] wait_reg, wait_next, retry_reg, retry_next, id_reg, id_next;
  logic [3:0] stat_reg, stat_next, mask_reg, mask_next, ev;
  logic [NCONN-1:0] used_reg, used_next;
  logic wr_go, hit;
  mbg_st_t st_reg, st_next;
  mbg_req_t job_reg, job_next, lq_reg, lq_next;
  logic [1:0] tries_reg, tries_next;
  logic [7:0] exc_reg, exc_next;
  mbg_frame_t rx_reg, rx_next;
  logic lq_v_reg, lq_v_next, lbusy_reg, lbusy_next;
  logic rsp_v_reg, rsp_v_next;
  mbg_rsp_t rsp_reg, rsp_next;
  logic req_fire, lrsp_fire, gw_grant, gw_req, expire, tmr_start, is_own;
  logic [2:0] fld_lsb;
  logic [1:0] ws_sel, rt_sel;

  // ----------------------------------------------------------------
  // axi4-lite slave and configuration registers
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full_reg && !bv_reg;
  assign s_axi_wready = !w_full_reg && !bv_reg;
  assign s_axi_arready = !rv_reg;
  assign wr_go = aw_full_reg && w_full_reg && !bv_reg;

  // write channels may land in either order; the write fires once both are held
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_next = aw_reg;
    w_full_next = w_full_reg;
    wd_next = wd_reg;
    wb_next = wb_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    port_next = port_reg;
    en_next = en_reg;
    wait_next = wait_reg;
    retry_next = retry_reg;
    id_next = id_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    used_next = used_reg;
    hit = 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      aw_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wd_next = s_axi_wdata;
      wb_next = s_axi_wstrb[0];
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bv_next = 1'b1;
      unique case (aw_reg)
        A_CTRL: begin
          if (wb_reg && wd_reg[1:0] != 2'd0) begin
            port_next = wd_reg[1:0];
            en_next = 1'b1;
          end
        end
        A_WAIT: if (wb_reg) wait_next = wd_reg[7:0];
        A_RETRY: if (wb_reg) retry_next = wd_reg[7:0];
        A_OWNID: if (wb_reg) id_next = wd_reg[7:0];
        A_SCAN: used_next = '0;
        A_STAT: if (wb_reg) stat_next = stat_reg & ~wd_reg[3:0];
        A_MASK: if (wb_reg) mask_next = wd_reg[3:0];
        A_STATE: hit = 1'b1;
        default: hit = 1'b0;
      endcase
      br_next = hit ? RESP_OK : RESP_SLVERR;
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rr_next = RESP_OK;
      unique case (s_axi_araddr)
        A_CTRL: rd_next = {29'h0, en_reg, port_reg};
        A_WAIT: rd_next = {24'h0, wait_reg};
        A_RETRY: rd_next = {24'h0, retry_reg};
        A_OWNID: rd_next = {24'h0, id_reg};
        A_SCAN: rd_next = {28'h0, used_reg};
        A_STAT: rd_next = {28'h0, stat_reg};
        A_MASK: rd_next = {28'h0, mask_reg};
        A_STATE: rd_next = {25'h0, tries_reg, st_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = RESP_SLVERR;
        end
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    // hardware sets win over a software clear in the same cycle
    stat_next = stat_next | ev;
    if (req_fire && !is_own && en_reg && st_reg == S_IDLE) begin
      used_next[tcp_req.conn] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_reg <= '0;
      w_full_reg <= 1'b0;
      wd_reg <= '0;
      wb_reg <= 1'b0;
      bv_reg <= 1'b0;
      br_reg <= RESP_OK;
      rv_reg <= 1'b0;
      rd_reg <= '0;
      rr_reg <= RESP_OK;
      port_reg <= 2'd0;
      en_reg <= 1'b0;
      wait_reg <= WAIT_RST;
      retry_reg <= RETRY_RST;
      id_reg <= OWNID_RST;
      mask_reg <= '0;
      stat_reg <= '0;
      used_reg <= '0;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_reg <= aw_next;
      w_full_reg <= w_full_next;
      wd_reg <= wd_next;
      wb_reg <= wb_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      port_reg <= port_next;
      en_reg <= en_next;
      wait_reg <= wait_next;
      retry_reg <= retry_next;
      id_reg <= id_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      used_reg <= used_next;
    end
  end

  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign irq = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // request intake and translation engine
  // ----------------------------------------------------------------
  assign fld_lsb = {2'(port_reg - 2'd1), 1'b0};
  assign ws_sel = wait_reg[fld_lsb +: FLD_W];
  assign rt_sel = retry_reg[fld_lsb +: FLD_W];
  assign is_own = (tcp_req.uid == id_reg);
  // a finished job owns the response slot first, so intake pauses meanwhile
  assign tcp_req_ready = !rsp_v_reg && !lbusy_reg && st_reg != S_DONE;
  assign loc_rsp_ready = lbusy_reg && !lq_v_reg && !rsp_v_reg && st_reg != S_DONE;
  assign req_fire = tcp_req_valid && tcp_req_ready;
  assign lrsp_fire = loc_rsp_valid && loc_rsp_ready;
  assign gw_req = en_reg && (st_reg == S_ARB || st_reg == S_SEND || st_reg == S_WAIT);
  assign tmr_start = st_reg == S_SEND && gw_grant && rtu_tx_ready;
  assign ev[ST_DONE] = st_reg == S_DONE && !rsp_v_reg && exc_reg == EXC_NONE;
  assign ev[ST_FAIL] = st_reg == S_DONE && !rsp_v_reg && exc_reg == EXC_NO_REPLY;
  assign ev[ST_BUSY] = req_fire && !is_own && en_reg
    && (used_reg[tcp_req.conn] || st_reg != S_IDLE);
  assign ev[ST_LOCAL] = lrsp_fire;

  always_comb begin
    st_next = st_reg;
    job_next = job_reg;
    tries_next = tries_reg;
    exc_next = exc_reg;
    rx_next = rx_reg;
    lq_next = lq_reg;
    lq_v_next = lq_v_reg && !loc_req_ready;
    lbusy_next = lbusy_reg && !lrsp_fire;
    rsp_v_next = rsp_v_reg && !tcp_rsp_ready;
    rsp_next = rsp_reg;
    if (req_fire) begin
      rsp_next = '{tid: tcp_req.tid, uid: tcp_req.uid,
                   fc: tcp_req.fc | 8'h80, data: 32'h0};
      if (is_own) begin
        lq_next = tcp_req;
        lq_v_next = 1'b1;
        lbusy_next = 1'b1;
      end else if (!en_reg) begin
        rsp_v_next = 1'b1;
        rsp_next.data = {EXC_PATH, 24'h0};
      end else if (ev[ST_BUSY]) begin
        rsp_v_next = 1'b1;
        rsp_next.data = {EXC_BUSY, 24'h0};
      end else begin
        job_next = tcp_req;
        tries_next = rt_sel;
        st_next = S_ARB;
      end
    end
    if (lrsp_fire) begin
      rsp_v_next = 1'b1;
      rsp_next = loc_rsp;
    end
    unique case (st_reg)
      S_IDLE: ;
      S_ARB: if (gw_grant) st_next = S_SEND;
      S_SEND: if (tmr_start) st_next = S_WAIT;
      S_WAIT: begin
        if (rtu_rx_valid && gw_grant && rtu_rx.uid == job_reg.uid) begin
          rx_next = rtu_rx;
          exc_next = EXC_NONE;
          st_next = S_DONE;
        end else if (expire && tries_reg != 2'd0) begin
          tries_next = tries_reg - 2'd1;
          st_next = S_SEND;
        end else if (expire) begin
          exc_next = EXC_NO_REPLY;
          st_next = S_DONE;
        end
      end
      S_DONE: begin
        if (!rsp_v_reg) begin
          rsp_v_next = 1'b1;
          rsp_next.tid = job_reg.tid;
          rsp_next.uid = job_reg.uid;
          rsp_next.fc = (exc_reg == EXC_NONE) ? rx_reg.fc : (job_reg.fc | 8'h80);
          rsp_next.data = (exc_reg == EXC_NONE) ? rx_reg.data : {exc_reg, 24'h0};
          st_next = S_IDLE;
        end
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= S_IDLE;
      job_reg <= '0;
      tries_reg <= 2'd0;
      exc_reg <= EXC_NONE;
      rx_reg <= '0;
      lq_reg <= '0;
      lq_v_reg <= 1'b0;
      lbusy_reg <= 1'b0;
      rsp_v_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      st_reg <= st_next;
      job_reg <= job_next;
      tries_reg <= tries_next;
      exc_reg <= exc_next;
      rx_reg <= rx_next;
      lq_reg <= lq_next;
      lq_v_reg <= lq_v_next;
      lbusy_reg <= lbusy_next;
      rsp_v_reg <= rsp_v_next;
      rsp_reg <= rsp_next;
    end
  end

  assign loc_req_valid = lq_v_reg;
  assign loc_req = lq_reg;
  assign tcp_rsp_valid = rsp_v_reg;
  assign tcp_rsp = rsp_reg;

  // ----------------------------------------------------------------
  // serial port sharing
  // ----------------------------------------------------------------
  mbg_arb u_arb (
    .aclk(aclk),
    .aresetn(aresetn),
    .gw_req(gw_req),
    .lm_req(lm_req),
    .gw_grant(gw_grant),
    .lm_grant(lm_grant)
  );

  mbg_timer #(.CYC(WAIT_CYCLES)) u_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tmr_start),
    .ws(ws_sel),
    .expire(expire)
  );

  // the owner of the port steers the transmit path
  assign rtu_port = en_reg ? 3'(3'b001 << (port_reg - 2'd1)) : 3'b000;
  assign rtu_tx_valid = gw_grant ? (st_reg == S_SEND) : (lm_grant && lm_tx_valid);
  assign rtu_tx = gw_grant
    ? mbg_frame_t'{uid: job_reg.uid, fc: job_reg.fc, data: job_reg.data} : lm_tx;
  assign lm_tx_ready = lm_grant && rtu_tx_ready;
  assign lm_rx_valid = lm_grant && rtu_rx_valid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_port_select: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_reg == A_CTRL && wb_reg && wd_reg[1:0] != 2'd0
    |=> port_reg == $past(wd_reg[1:0]) && en_reg)
    else $error("port selection not taken");
  a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_reg |-> !gw_grant && st_reg == S_IDLE)
    else $error("gateway active before port selection");
  a_own_local: assert property (@(posedge aclk) disable iff (!aresetn)
    req_fire && is_own |=> loc_req_valid && job_reg == $past(job_reg))
    else $error("own id request not served locally");
  a_retry_resend: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == S_WAIT && expire && tries_reg != 2'd0 && !(rtu_rx_valid && gw_grant)
    |=> st_reg == S_SEND && tries_reg == $past(tries_reg) - 2'd1)
    else $error("retry not issued after timeout");
  a_fail_code: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == S_WAIT && expire && tries_reg == 2'd0 && !(rtu_rx_valid && gw_grant)
    |=> st_reg == S_DONE && exc_reg == EXC_NO_REPLY)
    else $error("no-reply exception not raised");
  a_busy_code: assert property (@(posedge aclk) disable iff (!aresetn)
    ev[ST_BUSY] |=> rsp_v_reg && rsp_reg.fc[FC_EXC_BIT] && rsp_reg.data[31:24] == EXC_BUSY)
    else $error("busy exception missing");
  a_reset_bytes: assert property (@(posedge aclk)
    !aresetn |=> wait_reg == WAIT_RST && retry_reg == RETRY_RST)
    else $error("wait or retry byte wrong after reset");
  a_zero_retry: assert property (@(posedge aclk) disable iff (!aresetn)
    req_fire && st_next == S_ARB && rt_sel == 2'd0 |=> tries_reg == 2'd0)
    else $error("retries loaded while field is zero");
  a_ids_copied: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == S_DONE && !rsp_v_reg
    |=> rsp_v_reg && rsp_reg.tid == $past(job_reg.tid) && rsp_reg.uid == $past(job_reg.uid))
    else $error("transaction or unit id not copied");
endmodule : mbg_gateway
`default_nettype wire

// ===== mbg_rtu_slave.sv
`timescale 1ns/1ps
`default_nettype none
module mbg_rtu_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  input wire logic rtu_tx_valid,
  output logic rtu_tx_ready,
  input wire mbg_pkg::mbg_frame_t rtu_tx,
  output logic rtu_rx_valid,
  output mbg_pkg::mbg_frame_t rtu_rx,
  // bench control
  input wire logic silent,
  output int attempts
);
  import mbg_pkg::*;
  mbg_frame_t held;
  logic [2:0] gap;
  // takes a frame one cycle late so the sender must hold it; idle reply
  // lines toggle every cycle so stale data never passes for a reply
  always @(posedge aclk) begin
    rtu_rx_valid <= 1'b0;
    rtu_rx <= ~rtu_rx;
    rtu_tx_ready <= rtu_tx_valid && !rtu_tx_ready;
    if (rtu_tx_valid && rtu_tx_ready) begin
      attempts <= attempts + 1;
      held <= rtu_tx;
      gap <= silent ? 3'h0 : 3'h3;
    end else if (gap != 3'h0) begin
      gap <= gap - 3'h1;
      rtu_rx_valid <= (gap == 3'h1);
      rtu_rx <= '{held.uid, held.fc, ~held.data};
    end
    if (!aresetn) begin
      rtu_tx_ready <= 1'b0;
      rtu_rx_valid <= 1'b0;
      gap <= 3'h0;
      attempts <= 0;
      rtu_rx <= '0;
    end
  end
endmodule : mbg_rtu_slave
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mbg_pkg::*;
  localparam int WCYC = 20;
  logic aclk, aresetn, irq, silent;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tcp_req_valid, tcp_req_ready, tcp_rsp_valid, tcp_rsp_ready;
  logic loc_req_valid, loc_req_ready, loc_rsp_valid, loc_rsp_ready;
  logic rtu_tx_valid, rtu_tx_ready, rtu_rx_valid;
  logic lm_req, lm_grant, lm_tx_valid, lm_tx_ready, lm_rx_valid;
  logic [2:0] rtu_port;
  logic [15:0] tid;
  mbg_req_t tcp_req, loc_req;
  mbg_rsp_t tcp_rsp, loc_rsp, r;
  mbg_frame_t rtu_tx, rtu_rx, lm_tx;
  int n_errors, samples_checked, cyc, el, attempts, a0;

  mbg_gateway #(.WAIT_CYCLES(WCYC)) u_mbg_gateway (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .tcp_req_valid,
    .tcp_req_ready, .tcp_req, .tcp_rsp_valid, .tcp_rsp_ready, .tcp_rsp, .loc_req_valid,
    .loc_req_ready, .loc_req, .loc_rsp_valid, .loc_rsp_ready, .loc_rsp, .rtu_port,
    .rtu_tx_valid, .rtu_tx_ready, .rtu_tx, .rtu_rx_valid, .rtu_rx, .lm_req, .lm_grant,
    .lm_tx_valid, .lm_tx_ready, .lm_tx, .lm_rx_valid);
  mbg_rtu_slave u_mbg_rtu_slave (.aclk, .aresetn, .rtu_tx_valid, .rtu_tx_ready, .rtu_tx,
    .rtu_rx_valid, .rtu_rx, .silent, .attempts);

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic aw_pend, w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    // each channel released on its own handshake; local flags, as valid reads stale here
    while (aw_pend || w_pend) begin
      @(posedge aclk);
      if (aw_pend && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_pend = 1'b0;
      end
      if (w_pend && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_pend = 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd

  // one client request; response kept in r, its latency in el
  task automatic req(input logic [7:0] uid, input logic [1:0] cn);
    int t0;
    t0 = cyc;
    a0 = attempts;
    tid = tid + 16'h1;
    @(posedge aclk);
    tcp_req <= '{tid, uid, 8'h03, 32'h12345678, cn};
    {tcp_req_valid, tcp_rsp_ready} <= 2'h3;
    do @(posedge aclk); while (!tcp_req_ready);
    tcp_req_valid <= 1'b0;
    do @(posedge aclk); while (!tcp_rsp_valid);
    r = tcp_rsp;
    el = cyc - t0;
    tcp_rsp_ready <= 1'b0;
    check({r.tid, 8'h00, r.uid}, {tid, 8'h00, uid});
  endtask : req

  task automatic wrap_up;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // clock, own server, hang guard
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // own server is slow on purpose: ready one cycle after the request shows
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
    if (loc_req_valid && loc_req_ready) begin
      loc_req_ready <= 1'b0;
      loc_rsp_valid <= 1'b1;
      loc_rsp <= '{loc_req.tid, loc_req.uid, loc_req.fc, 32'hC0DE0001};
    end else begin
      loc_req_ready <= loc_req_valid;
      if (loc_rsp_ready) loc_rsp_valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {tcp_req_valid, tcp_rsp_ready, loc_req_ready, loc_rsp_valid, lm_req, lm_tx_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tcp_req, loc_rsp, lm_tx, silent, tid} = '0;
    {n_errors, samples_checked, cyc} = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_WAIT, d); check(d, 32'h00000055);
    rd(A_RETRY, d); check(d, 32'h000000AA);
    req(8'h22, 2'h0); check(32'(attempts - a0) | {24'h0, r.fc}, 32'h00000083);
    for (int p = 1; p <= 3; p++) begin
      wr(A_CTRL, 32'(p)); check({29'h0, rtu_port}, 32'h1 << (p - 1));
    end
    req(8'h01, 2'h1); check(r.data ^ 32'(attempts - a0), 32'hC0DE0001);
    // local master holds the port first; the gateway job must wait its turn
    lm_req <= 1'b1;
    fork
      req(8'h22, 2'h0);
      begin
        repeat (6) @(posedge aclk);
        check({31'h0, lm_grant && !rtu_tx_valid}, 32'h1);
        lm_req <= 1'b0;
      end
    join
    check(r.data ^ 32'(attempts - a0), 32'hEDCBA986);
    wr(A_MASK, 32'h00000004);
    req(8'h22, 2'h0); check({16'h0, r.fc, r.data[31:24]}, 32'h00008306);
    @(negedge aclk); check({31'h0, irq}, 32'h1);
    wr(A_STAT, 32'h00000004); check({31'h0, irq}, 32'h0);
    // silent slave: three attempts of one wait state each
    silent <= 1'b1;
    wr(A_SCAN, 32'h0);
    req(8'h22, 2'h0); check({16'h0, r.fc, r.data[31:24]}, 32'h0000830B);
    check(32'(attempts - a0), 32'h3);
    check({31'h0, el >= 3 * WCYC && el < 4 * WCYC}, 32'h1);
    repeat (40) @(posedge aclk);
    // third port alone: no retry, three wait states
    wr(A_RETRY, 32'h000000CF); wr(A_WAIT, 32'h00000030); wr(A_SCAN, 32'h0);
    req(8'h22, 2'h0); check(32'(attempts - a0), 32'h1);
    check({31'h0, el >= 3 * WCYC && el < 4 * WCYC}, 32'h1);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
